/* File: rtl/arwd_top.v */
// Conversion result registers and programmable window detector
`timescale 1ns/1ps
`include "arwd_regs.vh"

// What this block does
// - Right justify: result top four bits in high byte 3..0, rest in low byte.
// - Right justify: high byte 7..4 copy bit 3 if differential, else zero.
// - Left justify: top eight bits in high byte, low four in low byte 7..4.
// - Single-ended codes unsigned 12-bit; differential codes two's complement, 11 magnitude bits.
// - Every result is compared with the limits in hardware, setting the match flag.
// - In-range or out-of-range matching chosen only by relative limit values.
// - Each 16-bit limit is built from separately writable high and low bytes.
// - Greater-than limit high byte resets to all ones.
// - Both less-than limit bytes reset to all zeros.
// - Result bytes reset to zero and are readable and writable by software.
// - Justify select 0 gives right justification, 1 gives left justification.
// - Match flag stays set until reset or a software write of zero in a cycle with no match; a match wins over the write.
module arwd_top
#(
    parameter RES_W = 12
)
(
    input wire I_CORE_CLK,
    input wire I_SRST,
    input wire [7:0] I_SFR_ADDR,
    input wire I_SFR_WR,
    input wire I_SFR_RD,
    input wire [7:0] I_SFR_WDATA,
    output wire [7:0] O_SFR_RDATA,
    output wire O_SFR_HIT,
    input wire I_CONV_DONE,
    input wire [RES_W-1:0] I_CONV_RESULT,
    input wire I_CONV_DIFF,
    output wire O_WINDOW_MATCH,
    output wire O_JUSTIFY_SEL
);

// ---------------------------------------------------------------
// Register state
// ---------------------------------------------------------------
reg [7:0] res_lo_ff;
reg [7:0] res_hi_ff;
reg [7:0] gt_lo_ff;
reg [7:0] gt_hi_ff;
reg [7:0] lt_lo_ff;
reg [7:0] lt_hi_ff;
reg just_ff;
reg wflag_ff;
reg [7:0] rdata_ff;

reg [7:0] nxt_res_lo;
reg [7:0] nxt_res_hi;
reg [7:0] nxt_gt_lo;
reg [7:0] nxt_gt_hi;
reg [7:0] nxt_lt_lo;
reg [7:0] nxt_lt_hi;
reg nxt_just;
reg nxt_wflag;
reg [7:0] nxt_rdata;

// ---------------------------------------------------------------
// Address decode
// ---------------------------------------------------------------
reg sel_res_lo;
reg sel_res_hi;
reg sel_gt_lo;
reg sel_gt_hi;
reg sel_lt_lo;
reg sel_lt_hi;
reg sel_ctrl;

always @*
begin
    sel_res_lo = 1'b0;
    sel_res_hi = 1'b0;
    sel_gt_lo = 1'b0;
    sel_gt_hi = 1'b0;
    sel_lt_lo = 1'b0;
    sel_lt_hi = 1'b0;
    sel_ctrl = 1'b0;
    if (I_SFR_ADDR == `ARWD_ADDR_RES_LO)
        sel_res_lo = 1'b1;
    else if (I_SFR_ADDR == `ARWD_ADDR_RES_HI)
        sel_res_hi = 1'b1;
    else if (I_SFR_ADDR == `ARWD_ADDR_GT_LO)
        sel_gt_lo = 1'b1;
    else if (I_SFR_ADDR == `ARWD_ADDR_GT_HI)
        sel_gt_hi = 1'b1;
    else if (I_SFR_ADDR == `ARWD_ADDR_LT_LO)
        sel_lt_lo = 1'b1;
    else if (I_SFR_ADDR == `ARWD_ADDR_LT_HI)
        sel_lt_hi = 1'b1;
    else if (I_SFR_ADDR == `ARWD_ADDR_CTRL)
        sel_ctrl = 1'b1;
end

assign O_SFR_HIT = sel_res_lo | sel_res_hi | sel_gt_lo | sel_gt_hi |
                   sel_lt_lo | sel_lt_hi | sel_ctrl;

// ---------------------------------------------------------------
// Write enables
// ---------------------------------------------------------------
wire wr_res_lo;
wire wr_res_hi;
wire wr_gt_lo;
wire wr_gt_hi;
wire wr_lt_lo;
wire wr_lt_hi;
wire wr_ctrl;

assign wr_res_lo = I_SFR_WR & sel_res_lo;
assign wr_res_hi = I_SFR_WR & sel_res_hi;
assign wr_gt_lo = I_SFR_WR & sel_gt_lo;
assign wr_gt_hi = I_SFR_WR & sel_gt_hi;
assign wr_lt_lo = I_SFR_WR & sel_lt_lo;
assign wr_lt_hi = I_SFR_WR & sel_lt_hi;
assign wr_ctrl = I_SFR_WR & sel_ctrl;

// ---------------------------------------------------------------
// Formatting of the incoming conversion
// ---------------------------------------------------------------
wire [15:0] conv_word;

arwd_fmt
#(
    .RES_W(RES_W)
)
u_fmt
(
    .i_code(I_CONV_RESULT),
    .i_diff(I_CONV_DIFF),
    .i_left(just_ff),
    .o_word(conv_word)
);

// ---------------------------------------------------------------
// Window comparison
// ---------------------------------------------------------------
wire [15:0] gt_word;
wire [15:0] lt_word;
reg above_gt;
reg below_lt;
reg lt_over_gt;
reg win_hit;

assign gt_word = {gt_hi_ff, gt_lo_ff};
assign lt_word = {lt_hi_ff, lt_lo_ff};

always @*
begin
    if (I_CONV_DIFF)
    begin
        above_gt = $signed(conv_word) > $signed(gt_word);
        below_lt = $signed(conv_word) < $signed(lt_word);
        lt_over_gt = $signed(lt_word) > $signed(gt_word);
    end
    else
    begin
        above_gt = conv_word > gt_word;
        below_lt = conv_word < lt_word;
        lt_over_gt = lt_word > gt_word;
    end
    if (lt_over_gt)
        win_hit = above_gt & below_lt;
    else
        win_hit = above_gt | below_lt;
end

// ---------------------------------------------------------------
// Match event
// ---------------------------------------------------------------
wire win_set;
assign win_set = I_CONV_DONE & win_hit;

// ---------------------------------------------------------------
// Result registers
// ---------------------------------------------------------------
always @*
begin
    nxt_res_lo = res_lo_ff;
    nxt_res_hi = res_hi_ff;
    if (I_CONV_DONE)
    begin
        nxt_res_lo = conv_word[7:0];
        nxt_res_hi = conv_word[15:8];
    end
    else
    begin
        if (wr_res_lo)
            nxt_res_lo = I_SFR_WDATA;
        if (wr_res_hi)
            nxt_res_hi = I_SFR_WDATA;
    end
end

// ---------------------------------------------------------------
// Limit registers
// ---------------------------------------------------------------
always @*
begin
    nxt_gt_lo = gt_lo_ff;
    nxt_gt_hi = gt_hi_ff;
    nxt_lt_lo = lt_lo_ff;
    nxt_lt_hi = lt_hi_ff;
    if (wr_gt_lo)
        nxt_gt_lo = I_SFR_WDATA;
    if (wr_gt_hi)
        nxt_gt_hi = I_SFR_WDATA;
    if (wr_lt_lo)
        nxt_lt_lo = I_SFR_WDATA;
    if (wr_lt_hi)
        nxt_lt_hi = I_SFR_WDATA;
end

// ---------------------------------------------------------------
// Control bits and match flag
// ---------------------------------------------------------------
always @*
begin
    nxt_just = just_ff;
    nxt_wflag = wflag_ff;
    if (wr_ctrl)
    begin
        nxt_just = I_SFR_WDATA[`ARWD_CTRL_JUST_BIT];
        nxt_wflag = I_SFR_WDATA[`ARWD_CTRL_WFLAG_BIT];
    end
    if (win_set)
        nxt_wflag = 1'b1;
end

// ---------------------------------------------------------------
// Read data
// ---------------------------------------------------------------
wire [7:0] ctrl_word;
assign ctrl_word = {6'h00, wflag_ff, just_ff};

always @*
begin
    nxt_rdata = rdata_ff;
    if (I_SFR_RD)
    begin
        if (sel_res_lo)
            nxt_rdata = res_lo_ff;
        else if (sel_res_hi)
            nxt_rdata = res_hi_ff;
        else if (sel_gt_lo)
            nxt_rdata = gt_lo_ff;
        else if (sel_gt_hi)
            nxt_rdata = gt_hi_ff;
        else if (sel_lt_lo)
            nxt_rdata = lt_lo_ff;
        else if (sel_lt_hi)
            nxt_rdata = lt_hi_ff;
        else if (sel_ctrl)
            nxt_rdata = ctrl_word;
        else
            nxt_rdata = 8'h00;
    end
end

// ---------------------------------------------------------------
// State update
// ---------------------------------------------------------------
always @(posedge I_CORE_CLK)
begin
    if (I_SRST)
    begin
        res_lo_ff <= `ARWD_RST_RES_LO;
        res_hi_ff <= `ARWD_RST_RES_HI;
        gt_lo_ff <= `ARWD_RST_GT_LO;
        gt_hi_ff <= `ARWD_RST_GT_HI;
        lt_lo_ff <= `ARWD_RST_LT_LO;
        lt_hi_ff <= `ARWD_RST_LT_HI;
        just_ff <= `ARWD_RST_JUST;
        wflag_ff <= `ARWD_RST_WFLAG;
        rdata_ff <= `ARWD_RST_RDATA;
    end
    else
    begin
        res_lo_ff <= nxt_res_lo;
        res_hi_ff <= nxt_res_hi;
        gt_lo_ff <= nxt_gt_lo;
        gt_hi_ff <= nxt_gt_hi;
        lt_lo_ff <= nxt_lt_lo;
        lt_hi_ff <= nxt_lt_hi;
        just_ff <= nxt_just;
        wflag_ff <= nxt_wflag;
        rdata_ff <= nxt_rdata;
    end
end

// ---------------------------------------------------------------
// Outputs
// ---------------------------------------------------------------
assign O_SFR_RDATA = rdata_ff;
assign O_WINDOW_MATCH = wflag_ff;
assign O_JUSTIFY_SEL = just_ff;

endmodule // arwd_top

/* File: rtl/arwd_regs.vh */
// Register offsets, field positions and reset values of the result and window block
`ifndef ARWD_REGS_VH
`define ARWD_REGS_VH

// ---------------------------------------------------------------
// Register offsets on the special function register bus
// ---------------------------------------------------------------
`define ARWD_ADDR_RES_LO 8'hBE
`define ARWD_ADDR_RES_HI 8'hBF
`define ARWD_ADDR_GT_LO 8'hC4
`define ARWD_ADDR_GT_HI 8'hC5
`define ARWD_ADDR_LT_LO 8'hC6
`define ARWD_ADDR_LT_HI 8'hC7
`define ARWD_ADDR_CTRL 8'hE8

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define ARWD_CTRL_JUST_BIT 0
`define ARWD_CTRL_WFLAG_BIT 1

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define ARWD_RST_RES_LO 8'h00
`define ARWD_RST_RES_HI 8'h00
`define ARWD_RST_GT_LO 8'hFF
`define ARWD_RST_GT_HI 8'hFF
`define ARWD_RST_LT_LO 8'h00
`define ARWD_RST_LT_HI 8'h00
`define ARWD_RST_JUST 1'h0
`define ARWD_RST_WFLAG 1'h0
`define ARWD_RST_RDATA 8'h00

// ---------------------------------------------------------------
// Justification codes
// ---------------------------------------------------------------
`define ARWD_JUST_RIGHT 1'h0
`define ARWD_JUST_LEFT 1'h1

`endif

/* File: rtl/arwd_fmt.v */
// Result formatter: places a 12-bit conversion code into a 16-bit register word
`timescale 1ns/1ps

module arwd_fmt
#(
    parameter RES_W = 12
)
(
    input wire [RES_W-1:0] i_code,
    input wire i_diff,
    input wire i_left,
    output wire [15:0] o_word
);

// ---------------------------------------------------------------
// Right and left layouts
// ---------------------------------------------------------------
wire [15:0] right_word;
wire [15:0] left_word;
wire fill_bit;

assign fill_bit = i_diff & i_code[RES_W-1];

genvar gi;
generate
    for (gi = RES_W; gi < 16; gi = gi + 1)
    begin : g_ext
        assign right_word[gi] = fill_bit;
    end
endgenerate

assign right_word[RES_W-1:0] = i_code;
assign left_word = {i_code, {(16-RES_W){1'b0}}};
assign o_word = i_left ? left_word : right_word;

endmodule // arwd_fmt

/* File: sim/arwd_chk_sva.sv */
// Port checker of the result and window block
`timescale 1ns/1ps
module arwd_chk (
    input wire I_CORE_CLK,
    input wire I_SRST,
    input wire [7:0] I_SFR_ADDR,
    input wire I_SFR_WR,
    input wire I_SFR_RD,
    input wire [7:0] I_SFR_WDATA,
    input wire [7:0] O_SFR_RDATA,
    input wire O_SFR_HIT,
    input wire I_CONV_DONE,
    input wire O_WINDOW_MATCH,
    input wire O_JUSTIFY_SEL
);
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (I_SRST);
    wire clr_w = I_SFR_WR && I_SFR_ADDR == 8'hE8 && !I_SFR_WDATA[1];
    sequence s_ctl_wr;
        I_SFR_WR && I_SFR_ADDR == 8'hE8;
    endsequence
    sequence s_ctl_rd;
        I_SFR_RD && I_SFR_ADDR == 8'hE8;
    endsequence
    AST_HIT: assert property (O_SFR_HIT == (I_SFR_ADDR inside {8'hBE, 8'hBF,
        8'hC4, 8'hC5, 8'hC6, 8'hC7, 8'hE8})) else $error("decode wrong");
    AST_JUST: assert property (s_ctl_wr |=> O_JUSTIFY_SEL == $past(I_SFR_WDATA[0]))
        else $error("justify not written");
    AST_JHOLD: assert property (!I_SFR_WR |=> $stable(O_JUSTIFY_SEL))
        else $error("justify moved");
    AST_STICK: assert property (O_WINDOW_MATCH && !clr_w |=> O_WINDOW_MATCH)
        else $error("flag dropped");
    AST_CLR: assert property (clr_w && !I_CONV_DONE |=> !O_WINDOW_MATCH)
        else $error("flag not cleared");
    AST_NOSET: assert property (!O_WINDOW_MATCH && !I_CONV_DONE && !I_SFR_WR
        |=> !O_WINDOW_MATCH) else $error("flag set without cause");
    AST_RDHOLD: assert property (!I_SFR_RD |=> $stable(O_SFR_RDATA))
        else $error("read data moved");
    AST_UNMAP: assert property (I_SFR_RD && !O_SFR_HIT |=> O_SFR_RDATA == 8'h00)
        else $error("unmapped read not zero");
    AST_CTLRD: assert property (s_ctl_rd |=> O_SFR_RDATA == {6'h00,
        $past(O_WINDOW_MATCH), $past(O_JUSTIFY_SEL)}) else $error("control read wrong");
endmodule // arwd_chk
bind arwd_top arwd_chk i_chk (.I_CORE_CLK(I_CORE_CLK), .I_SRST(I_SRST),
    .I_SFR_ADDR(I_SFR_ADDR), .I_SFR_WR(I_SFR_WR), .I_SFR_RD(I_SFR_RD),
    .I_SFR_WDATA(I_SFR_WDATA), .O_SFR_RDATA(O_SFR_RDATA), .O_SFR_HIT(O_SFR_HIT),
    .I_CONV_DONE(I_CONV_DONE), .O_WINDOW_MATCH(O_WINDOW_MATCH),
    .O_JUSTIFY_SEL(O_JUSTIFY_SEL));

/* File: sim/arwd_core_model.sv */
// Converter core model: one result per start request
`timescale 1ns/1ps
module arwd_core_model (
    input wire i_clk,
    input wire i_start,
    input wire [11:0] i_code,
    input wire i_diff,
    output logic o_done = 1'b0,
    output logic [11:0] o_result = 12'h000,
    output logic o_diff = 1'b0
);
    // Lines not valid outside the done pulse
    always @(posedge i_clk)
    begin
        o_done <= i_start;
        o_result <= i_start ? i_code : ~o_result;
        o_diff <= i_start ? i_diff : ~o_diff;
    end
endmodule // arwd_core_model

/* File: sim/tb_top.sv */
// Self-checking bench of the result and window block
`timescale 1ns/1ps
module tb_top;
    logic clk = 0, srst = 1, wr = 0, rd = 0, st = 0, sd = 0, d, done, dif, hit, wm, js, ef, ej;
    logic [7:0] adr = 0, wd = 0, rdat;
    logic [11:0] sc = 0, res, c;
    logic [15:0] w, g, l;
    logic [7:0] ra[8] = '{8'hBE, 8'hBF, 8'hC4, 8'hC5, 8'hC6, 8'hC7, 8'hE8, 8'h00};
    logic [7:0] rv[8] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
    int n_errors = 0, checks = 0;
    initial forever #50 clk = ~clk;
    arwd_core_model i_core (.i_clk(clk), .i_start(st), .i_code(sc), .i_diff(sd),
        .o_done(done), .o_result(res), .o_diff(dif));
    arwd_top i_dut (.I_CORE_CLK(clk), .I_SRST(srst), .I_SFR_ADDR(adr), .I_SFR_WR(wr),
        .I_SFR_RD(rd), .I_SFR_WDATA(wd), .O_SFR_RDATA(rdat), .O_SFR_HIT(hit),
        .I_CONV_DONE(done), .I_CONV_RESULT(res), .I_CONV_DIFF(dif),
        .O_WINDOW_MATCH(wm), .O_JUSTIFY_SEL(js));
    function automatic logic [15:0] fmt(logic [11:0] c, logic d, logic j);
        return j ? {c, 4'h0} : {{4{d & c[11]}}, c};
    endfunction
    function automatic logic mt(logic [15:0] w, logic [15:0] g, logic [15:0] l, logic d);
        int a, b, e;
        a = d ? $signed(w) : $signed({1'b0, w});
        b = d ? $signed(g) : $signed({1'b0, g});
        e = d ? $signed(l) : $signed({1'b0, l});
        return e > b ? (a > b && a < e) : (a > b || a < e);
    endfunction
    task results;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(logic [7:0] s, logic [7:0] e);
        checks++;
        if (s !== e)
        begin
            n_errors++;
            $display("unexpected at %0t: read %h want %h", $time, s, e);
        end
    endtask
    task cyc;
        @(posedge clk);
        #10;
    endtask
    task wrr(logic [7:0] a, logic [7:0] v);
        adr = a; wd = v; wr = 1; cyc;
        wr = 0; cyc;
    endtask
    task rc(logic [7:0] a, logic [7:0] e);
        adr = a; rd = 1; cyc;
        rd = 0; chk(rdat, e); cyc;
    endtask
    task cv(logic [11:0] v, logic df);
        sc = v; sd = df; st = 1; cyc;
        st = 0; cyc;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        results;
    end
    initial
    begin
        void'($urandom(38845));
        repeat (10) @(posedge clk);
        #10 srst = 0;
        cyc;
        foreach (ra[i]) rc(ra[i], rv[i]);
        wrr(8'hBE, 8'h5A); wrr(8'hBF, 8'hA5); wrr(8'h00, 8'h77);
        rc(8'hBE, 8'h5A);
        rc(8'hBF, 8'hA5);
        g = 16'hFFFF; l = 0; ef = 0;
        for (int i = 0; i < 40; i++)
        begin
            ej = 1'($urandom_range(1));
            if (i > 1) begin g = 16'($urandom_range(65535)); l = 16'($urandom_range(65535)); end
            if (i == 1) g = 16'h0800;
            wrr(8'hC4, g[7:0]); wrr(8'hC5, g[15:8]); wrr(8'hC6, l[7:0]); wrr(8'hC7, l[15:8]);
            if (i % 4 == 0) ef = 0;
            wrr(8'hE8, {6'h00, ef, ej});
            chk({7'h00, js}, {7'h00, ej});
            c = i == 0 ? 12'hFFF : i == 1 ? 12'h801 : 12'($urandom_range(4095));
            d = i > 1 ? 1'($urandom_range(1)) : 1'b0;
            cv(c, d);
            w = fmt(c, d, ej);
            ef = ef | mt(w, g, l, d);
            rc(8'hBF, w[15:8]);
            rc(8'hBE, w[7:0]);
            rc(8'hE8, {6'h00, ef, ej});
        end
        // Result byte write in the conversion cycle is dropped
        sc = 12'h3C5; sd = 0; st = 1; cyc;
        st = 0; wrr(8'hBE, 8'h33);
        w = fmt(12'h3C5, 1'b0, ej);
        rc(8'hBE, w[7:0]);
        rc(8'hBF, w[15:8]);
        // Match in the same cycle as a flag clear keeps the flag set
        wrr(8'hC4, 8'h00); wrr(8'hC5, 8'h00); wrr(8'hC6, 8'h00); wrr(8'hC7, 8'h00);
        sc = 12'hFFF; st = 1; cyc;
        st = 0; wrr(8'hE8, {7'h00, ej});
        rc(8'hE8, {6'h00, 1'b1, ej});
        results;
    end
endmodule // tb_top
